// [hdl/eew_pkg.sv]
package eew_pkg;

   // Array and page geometry.
   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 12;
   localparam int PAGE_W     = 5;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_CNT   = 128;
   localparam int PAGE_IDX_W = 7;
   localparam int SEL_W      = 3;

   // Device address word layout.
   localparam logic [3:0] DEV_ARRAY = 4'ha;
   localparam logic [3:0] DEV_IDPG  = 4'hb;
   localparam int TYPE_LSB       = 4;
   localparam int SEL_LSB        = 1;
   localparam int RW_BIT         = 0;
   localparam int HI_ADDR_W      = 4;
   // Lock select sits in bit 2 of the first word-address byte.
   localparam int LOCK_SEL_BIT   = 2;
   localparam int LOCK_DATA_BIT  = 1;

   // Bit counter marks within one nine-clock word.
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_ACK   = 4'h7;
   localparam logic [3:0] BIT_LAST  = 4'h8;

   // Program cycle time, longest figure, rounded down to clock cycles.
   localparam longint PROG_TIME_NS  = 3000000;
   localparam longint CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_CYCLES = int'(PROG_TIME_NS / CLK_PERIOD_NS);

   // Reset values.
   localparam logic [ADDR_W-1:0] WORD_ADDR_RST = 12'h000;
   localparam logic              STANDBY_RST   = 1'b1;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_WA1  = 3'b010,
      L_WA2  = 3'b011,
      L_DATA = 3'b100
   } eew_link_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_COPY = 2'b01,
      S_WAIT = 2'b10
   } eew_sys_t;

   typedef enum logic [1:0] {
      K_NONE  = 2'b00,
      K_ARRAY = 2'b01,
      K_ID    = 2'b10,
      K_LOCK  = 2'b11
   } eew_kind_t;

   // Write staged by the link for the program cycle.
   typedef struct packed {
      eew_kind_t              kind;
      logic [PAGE_IDX_W-1:0]  page;
      logic                   seq;
   } eew_stage_t;

   localparam eew_stage_t STAGE_RST = '{kind: K_NONE, page: 7'h00, seq: 1'b0};

endpackage

// [hdl/eew_target.sv]
// Functional notes
// - SDA falling while SCL high is a start; it begins every command.
// - SDA rising while SCL high is a stop; it ends the transfer.
// - Data changes only with SCL low; high-phase changes mean start or stop.
// - Bits are sampled on SCL rise; acknowledges are driven on SCL fall.
// - SDA is only pulled low or released, never driven high.
// - Words are eight bits MSB first; acknowledge is SDA low on clock nine.
// - Standby at power-up and after stop once internal work is done.
// - First byte after start is device address: type, three selects, direction.
// - Received select bits must equal the three select pins.
// - An unconnected select pin reads as low; here the select pins go through the sync flops with no pull-down.
// - Address bit zero selects read when one, write when zero.
// - Matching address is acknowledged; mismatch gets none and goes idle.
// - Array is 128 pages of 32 bytes, twelve-bit word address.
// - Byte write: two address bytes, one data byte, all acknowledged, then stop.
// - After write stop, timed program cycle up to 3 ms ignores inputs.
// - Page write takes 32 bytes; low five address bits wrap in page.
// - Write-inhibit high protects the whole array; low allows writes.
// - Id page write uses page format, type 1011b, lock select zero.
// - Five low address bits pick the byte in the id page.
// - Once locked, id page write data bytes get no acknowledge.
// - Polling address is acknowledged only after the program cycle ends.
// - Type 1011b, lock select one, data bit one locks the id page.
// - Word address counter keeps last address plus one between operations.
`timescale 1ns/1ps
module eew_target
   import eew_pkg::*;
#(
   parameter int unsigned PROG_CYC = PROG_CYCLES
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              cen,
   input  wire logic              scl_clk,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   input  wire logic              chip_select_bit_2,
   input  wire logic              chip_select_bit_1,
   input  wire logic              chip_select_bit_0,
   input  wire logic              write_inhibit,
   output logic                   standby,
   output logic                   busy,
   output logic                   id_locked,
   output logic [ADDR_W-1:0]      word_addr,
   input  wire logic [ADDR_W-1:0] peek_addr,
   input  wire logic              peek_id,
   output logic [DATA_W-1:0]      peek_data
);

   // Start and stop detectors clocked by SDA itself, gated by SCL high.
   logic start_tgl_q;
   logic stop_tgl_q;

   always_ff @(negedge sda_in or negedge nrst) begin
      if (!nrst) begin
         start_tgl_q <= 1'b0;
      end else if (scl_clk) begin
         start_tgl_q <= ~start_tgl_q;
      end
   end

   always_ff @(negedge nrst or posedge sda_in) begin
      if (!nrst) begin
         stop_tgl_q <= 1'b0;
      end else if (scl_clk) begin
         stop_tgl_q <= ~stop_tgl_q;
      end
   end

   // ---------------- Link domain (SCL) ----------------
   logic                    sda_pos_q;
   logic [5:0]              lsync1_q;
   logic [5:0]              lsync2_q;
   logic                    start_ack_q;
   eew_link_t               ls_q;
   eew_link_t               ls_d;
   logic [3:0]              bc_q;
   logic [3:0]              bc_d;
   logic                    oe_d;
   logic                    sda_oe_q;
   logic [DATA_W-2:0]       sh_q;
   logic                    id_sel_q;
   logic                    rw_q;
   logic [DATA_W-1:0]       hi_q;
   logic [ADDR_W-1:0]       wa_q;
   eew_stage_t              stage_q;
   logic [PAGE_BYTES-1:0]   mask_q;
   logic [DATA_W-1:0]       buf_q [PAGE_BYTES];

   always_ff @(posedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         sda_pos_q <= 1'b1;
      end else begin
         sda_pos_q <= sda_in;
      end
   end

   // Pins and system status reach the link through two flops.
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         lsync1_q <= '0;
         lsync2_q <= '0;
      end else begin
         lsync1_q <= {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0,
                      write_inhibit, id_locked, busy};
         lsync2_q <= lsync1_q;
      end
   end

   // select pins read zero from reset until sampled; a floating pin is sampled as is, not forced to zero
   wire [SEL_W-1:0]  sel_s    = lsync2_q[5:3];
   wire              wp_s     = lsync2_q[2];
   wire              locked_s = lsync2_q[1];
   wire              busy_s   = lsync2_q[0];

   // The toggle is steady since SDA fell during the SCL high phase.
   wire              start_hit = start_tgl_q ^ start_ack_q;
   wire [DATA_W-1:0] rx_byte   = {sh_q, sda_pos_q};
   wire              byte_end  = (bc_q == BIT_ACK);
   wire              type_hit  = (rx_byte[7:TYPE_LSB] == DEV_ARRAY) ||
                                 (rx_byte[7:TYPE_LSB] == DEV_IDPG);
   wire              sel_hit   = (rx_byte[TYPE_LSB-1:SEL_LSB] == sel_s);
   wire              addr_ack  = type_hit & sel_hit & ~busy_s;
   wire              lock_cmd  = id_sel_q & hi_q[LOCK_SEL_BIT];
   wire              do_lock   = lock_cmd & rx_byte[LOCK_DATA_BIT];
   wire              data_ack  = ~wp_s & ~(id_sel_q & locked_s);
   wire              store     = (ls_q == L_DATA) & byte_end & data_ack;
   wire              arm       = store & (~lock_cmd | do_lock);
   // only the low five bits advance
   wire [ADDR_W-1:0] wa_next   = {wa_q[ADDR_W-1:PAGE_W], wa_q[PAGE_W-1:0] + 5'h01};
   wire eew_kind_t   kind_next = !id_sel_q ? K_ARRAY : (lock_cmd ? K_LOCK : K_ID);

   always_comb begin
      ls_d = ls_q;
      bc_d = bc_q;
      oe_d = 1'b0;
      if (start_hit) begin
         ls_d = L_ADDR;
         bc_d = BIT_FIRST;
      end else if (ls_q != L_IDLE) begin
         if (bc_q == BIT_LAST) begin
            bc_d = BIT_FIRST;
            if (!sda_oe_q) begin
               ls_d = L_IDLE;
            end else begin
               case (ls_q)
                  L_ADDR:  ls_d = rw_q ? L_IDLE : L_WA1;
                  L_WA1:   ls_d = L_WA2;
                  L_WA2:   ls_d = L_DATA;
                  L_DATA:  ls_d = L_DATA;
                  default: ls_d = L_IDLE;
               endcase
            end
         end else if (byte_end) begin
            bc_d = BIT_LAST;
            case (ls_q)
               L_ADDR:  oe_d = addr_ack;
               L_WA1:   oe_d = 1'b1;
               L_WA2:   oe_d = 1'b1;
               L_DATA:  oe_d = data_ack;
               default: oe_d = 1'b0;
            endcase
         end else begin
            bc_d = bc_q + 4'h1;
         end
      end
   end

   // state and acknowledge move on falling SCL
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         ls_q        <= L_IDLE;
         bc_q        <= BIT_FIRST;
         sda_oe_q    <= 1'b0;
         start_ack_q <= 1'b0;
      end else begin
         ls_q        <= ls_d;
         bc_q        <= bc_d;
         sda_oe_q    <= oe_d;
         start_ack_q <= start_tgl_q;
      end
   end

   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         sh_q <= '0;
      end else if (bc_q < BIT_ACK) begin
         sh_q <= rx_byte[DATA_W-2:0];
      end
   end

   // direction and type caught on address acknowledge
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         id_sel_q <= 1'b0;
         rw_q     <= 1'b0;
         hi_q     <= '0;
      end else if (!start_hit && byte_end) begin
         if (ls_q == L_ADDR && addr_ack) begin
            id_sel_q <= rx_byte[TYPE_LSB];
            rw_q     <= rx_byte[RW_BIT];
         end
         if (ls_q == L_WA1) begin
            hi_q <= rx_byte;
         end
      end
   end

   // twelve-bit word address from both bytes
   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         wa_q    <= WORD_ADDR_RST;
         stage_q <= STAGE_RST;
         mask_q  <= '0;
      end else if (!start_hit && byte_end) begin
         if (ls_q == L_WA2) begin
            wa_q         <= {hi_q[HI_ADDR_W-1:0], rx_byte};
            mask_q       <= '0;
            stage_q.kind <= K_NONE;
            stage_q.seq  <= ~stage_q.seq;
         end
         // counter keeps last address plus one
         if (store) begin
            wa_q                   <= wa_next;
            mask_q[wa_q[PAGE_W-1:0]] <= 1'b1;
         end
         // lock only with data bit one
         if (arm) begin
            stage_q.kind <= kind_next;
            stage_q.page <= wa_q[ADDR_W-1:PAGE_W];
         end
      end
   end

   // low five bits place the byte in the page buffer
   always_ff @(negedge scl_clk) begin
      if (!start_hit && store) begin
         buf_q[wa_q[PAGE_W-1:0]] <= rx_byte;
      end
   end

   // open drain: pull low or release
   assign sda_out   = 1'b0;
   assign sda_oe    = sda_oe_q;
   assign word_addr = wa_q;

   // ---------------- System domain ----------------
   logic [1:0]              ssync1_q;
   logic [1:0]              ssync2_q;
   logic [1:0]              sseen_q;
   eew_sys_t                sst_q;
   logic [PAGE_W-1:0]       idx_q;
   logic [31:0]             cnt_q;
   logic                    done_seq_q;
   logic                    busy_q;
   logic                    locked_q;
   logic                    standby_q;
   logic [DATA_W-1:0]       peek_q;
   logic [DATA_W-1:0]       mem [PAGE_CNT*PAGE_BYTES];
   logic [DATA_W-1:0]       idpg [PAGE_BYTES];

   wire stop_evt  = ssync2_q[1] ^ sseen_q[1];
   wire start_evt = ssync2_q[0] ^ sseen_q[0];
   // The staged write is steady: the link is quiet once a stop is seen.
   wire new_write = (stage_q.seq != done_seq_q);
   // nothing armed means no program cycle
   wire prog_go   = stop_evt && (sst_q == S_IDLE) && new_write && (stage_q.kind != K_NONE);
   wire copy_hit  = (sst_q == S_COPY) && mask_q[idx_q];
   wire wait_end  = (cnt_q == PROG_CYC - 32'd1);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ssync1_q <= '0;
         ssync2_q <= '0;
         sseen_q  <= '0;
      end else if (cen) begin
         ssync1_q <= {stop_tgl_q, start_tgl_q};
         ssync2_q <= ssync1_q;
         sseen_q  <= ssync2_q;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sst_q      <= S_IDLE;
         idx_q      <= '0;
         cnt_q      <= '0;
         done_seq_q <= 1'b0;
         busy_q     <= 1'b0;
      end else if (cen) begin
         if (stop_evt && sst_q == S_IDLE) begin
            done_seq_q <= stage_q.seq;
         end
         case (sst_q)
            S_IDLE: begin
               if (prog_go) begin
                  sst_q  <= S_COPY;
                  idx_q  <= '0;
                  cnt_q  <= '0;
                  busy_q <= 1'b1;
               end
            end
            S_COPY: begin
               idx_q <= idx_q + 5'h01;
               cnt_q <= cnt_q + 32'd1;
               if (idx_q == 5'h1f) begin
                  sst_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               cnt_q <= cnt_q + 32'd1;
               if (wait_end) begin
                  sst_q  <= S_IDLE;
                  busy_q <= 1'b0;
               end
            end
            default: sst_q <= S_IDLE;
         endcase
      end
   end

   // standby at power-up and after stop with no work left
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         standby_q <= STANDBY_RST;
         locked_q  <= 1'b0;
      end else if (cen) begin
         if (start_evt) begin
            standby_q <= 1'b0;
         end else if ((stop_evt && !prog_go && !busy_q) || (sst_q == S_WAIT && wait_end)) begin
            standby_q <= 1'b1;
         end
         if (prog_go && stage_q.kind == K_LOCK) begin
            locked_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (cen) begin
         if (copy_hit && stage_q.kind == K_ARRAY) begin
            mem[{stage_q.page, idx_q}] <= buf_q[idx_q];
         end
         // id page write lands in the separate page
         if (copy_hit && stage_q.kind == K_ID) begin
            idpg[idx_q] <= buf_q[idx_q];
         end
         peek_q <= peek_id ? idpg[peek_addr[PAGE_W-1:0]] : mem[peek_addr];
      end
   end

   assign busy      = busy_q;
   assign id_locked = locked_q;
   assign standby   = standby_q;
   assign peek_data = peek_q;

   // ---------------- Checks ----------------
   a_addr_ack_hit: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (!start_hit && ls_q == L_ADDR && byte_end && addr_ack) |=> sda_oe)
      else $error("matching address not acknowledged");

   a_sel_miss_nack: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (ls_q == L_ADDR && byte_end && !sel_hit) |=> !sda_oe)
      else $error("foreign select acknowledged");

   a_busy_poll_nack: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (ls_q == L_ADDR && byte_end && busy_s) |=> !sda_oe ##1 (ls_q == L_IDLE || start_hit))
      else $error("address acknowledged during program cycle");

   a_wp_data_nack: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (ls_q == L_DATA && byte_end && wp_s) |=> !sda_oe && $stable(mask_q))
      else $error("data taken under write-inhibit");

   a_lock_data_nack: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (ls_q == L_DATA && byte_end && id_sel_q && locked_s) |=> !sda_oe)
      else $error("locked id page data acknowledged");

   sequence s_ack_clock;
      sda_oe ##1 !sda_oe;
   endsequence
   a_ack_one_clock: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      $rose(sda_oe) |-> s_ack_clock)
      else $error("acknowledge not exactly one clock");

   a_page_wrap: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      (store && !start_hit) |=> wa_q[ADDR_W-1:PAGE_W] == $past(wa_q[ADDR_W-1:PAGE_W]) &&
                                wa_q[PAGE_W-1:0] == $past(wa_q[PAGE_W-1:0]) + 5'h01)
      else $error("page pointer left its page");

   a_start_restart: assert property (
      @(negedge scl_clk) disable iff (!nrst)
      start_hit |=> ls_q == L_ADDR && bc_q == BIT_FIRST && !sda_oe)
      else $error("start did not restart address phase");

   sequence s_prog_run;
      busy[*8] ##0 !standby;
   endsequence
   a_prog_busy: assert property (
      @(posedge clock) disable iff (!nrst)
      (prog_go && cen) |=> s_prog_run)
      else $error("program cycle cut short");

   a_prog_end: assert property (
      @(posedge clock) disable iff (!nrst)
      (cen && sst_q == S_WAIT && wait_end && !start_evt) |=> !busy && standby)
      else $error("standby not entered after program cycle");

endmodule // eew_target

// [test/eew_master.sv]
`timescale 1ns/1ps
module eew_master (
   output logic      scl_clk,
   output logic      sda_pull,
   input  wire logic sda
);
   localparam realtime Q = 3.75;

   initial begin
      scl_clk  = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic clk_bit(input logic b, output logic r);
      sda_pull = ~b;
      #Q scl_clk = 1'b1;
      #Q r = sda;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   task automatic start();
      sda_pull = 1'b0;
      #Q scl_clk = 1'b1;
      #Q sda_pull = 1'b1;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   task automatic stop();
      sda_pull = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_pull = 1'b0;
      #1200;
   endtask

   task automatic recover();
      logic r;
      r       = 1'b0;
      scl_clk = 1'b0;
      for (int i = 0; i < 9 && r !== 1'b1; i++) begin
         #Q;
         clk_bit(1'b1, r);
      end
      #Q scl_clk = 1'b1;
      #Q;
   endtask

   task automatic frame(input logic [7:0] b[$], output logic [63:0] acks);
      logic r;
      acks = '0;
      start();
      foreach (b[i]) begin
         for (int k = 7; k >= 0; k--) begin
            clk_bit(b[i][k], r);
         end
         clk_bit(1'b1, r);
         acks[i] = ~r;
         if (r !== 1'b0) break;
      end
      stop();
   endtask
endmodule // eew_master

// [test/test_eew_target.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module test_eew_target;
   import eew_pkg::*;
   localparam int unsigned PCYC = 60;
   localparam logic [2:0]  SEL  = 3'h5;
   localparam logic [7:0]  DEVW = {DEV_ARRAY, SEL, 1'b0};
   localparam logic [7:0]  IDW  = {DEV_IDPG, SEL, 1'b0};
   localparam logic [7:0]  ADR_T [5] = '{8'hac, 8'hae, 8'h9a, 8'hab, 8'ha0};
   localparam logic [2:0]  PIN_T [5] = '{SEL, SEL, SEL, SEL, 3'h0};
   localparam logic        ACK_T [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   logic              clock, nrst, cen, scl_clk, sda_pull, sda_wire, sda_out, sda_oe;
   logic [SEL_W-1:0]  sel_pins;
   logic              write_inhibit, standby, busy, id_locked, peek_id;
   logic [ADDR_W-1:0] word_addr, peek_addr;
   logic [DATA_W-1:0] peek_data;
   logic [63:0]       acks;
   logic [7:0]        q[$];
   int                fail_count = 0;
   int                n_tests = 0;
   int                j;

   // Open-drain wire with pull-up: low when either party pulls.
   assign sda_wire = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

   eew_target #(.PROG_CYC(PCYC)) i_eew_target (
      .clock(clock), .nrst(nrst), .cen(cen), .scl_clk(scl_clk), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_2(sel_pins[2]),
      .chip_select_bit_1(sel_pins[1]), .chip_select_bit_0(sel_pins[0]),
      .write_inhibit(write_inhibit), .standby(standby), .busy(busy),
      .id_locked(id_locked), .word_addr(word_addr), .peek_addr(peek_addr),
      .peek_id(peek_id), .peek_data(peek_data)
   );

   eew_master i_eew_master (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda_wire));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic settle(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic wait_ready();
      for (int i = 0; i < 300 && busy !== 1'b0; i++) begin
         @(negedge clock);
      end
      settle(2);
   endtask

   task automatic peek(input logic id, input logic [11:0] a, input logic [7:0] exp);
      @(negedge clock);
      peek_id   = id;
      peek_addr = a;
      settle(2);
      `CHK(peek_data, exp)
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #400000;
      fail_count++;
      give_verdict();
   end

   initial begin
      nrst          = 1'b0;
      cen           = 1'b1;
      write_inhibit = 1'b0;
      sel_pins      = SEL;
      peek_id       = 1'b0;
      peek_addr     = '0;
      settle(12);
      `CHK({standby, busy, id_locked, sda_oe}, 4'h8)
      `CHK(word_addr, WORD_ADDR_RST)
      nrst = 1'b1;
      settle(2);
      i_eew_master.recover();
      $display("test reset done");

      q = '{DEVW, 8'h03, 8'h45, 8'h9c};
      i_eew_master.frame(q, acks);
      `CHK(acks[3:0], 4'hf)
      `CHK({busy, standby}, 2'h2)
      settle(1);
      cen = 1'b0;
      settle(PCYC + 10);
      `CHK(busy, 1'b1)
      cen = 1'b1;
      q = '{DEVW};
      i_eew_master.frame(q, acks);
      `CHK(acks[0], 1'b0)
      wait_ready();
      `CHK(standby, 1'b1)
      i_eew_master.frame(q, acks);
      `CHK(acks[0], 1'b1)
      `CHK(word_addr, 12'h346)
      peek(1'b0, 12'h345, 8'h9c);
      $display("test byte write done");

      for (int i = 0; i < 5; i++) begin
         @(negedge clock);
         sel_pins = PIN_T[i];
         q = '{ADR_T[i]};
         i_eew_master.frame(q, acks);
         `CHK(acks[0], ACK_T[i])
         `CHK(busy, 1'b0)
      end
      @(negedge clock);
      sel_pins = SEL;
      $display("test addressing done");

      q = '{DEVW, 8'h00, 8'hbe};
      for (int i = 0; i < 34; i++) begin
         q.push_back(8'(8'h40 + i));
      end
      i_eew_master.frame(q, acks);
      `CHK(acks[36:0], {37{1'b1}})
      wait_ready();
      `CHK(word_addr, 12'h0a0)
      for (int k = 0; k < PAGE_BYTES; k++) begin
         j = (k + 2) % PAGE_BYTES;
         if (j < 2) begin
            j += PAGE_BYTES;
         end
         peek(1'b0, {7'd5, 5'(k)}, 8'(8'h40 + j));
      end
      $display("test page wrap done");

      @(negedge clock);
      write_inhibit = 1'b1;
      q = '{DEVW, 8'h03, 8'h45, 8'h11};
      i_eew_master.frame(q, acks);
      `CHK(acks[3:0], 4'h7)
      settle(10);
      `CHK(busy, 1'b0)
      peek(1'b0, 12'h345, 8'h9c);
      write_inhibit = 1'b0;
      $display("test inhibit done");

      q = '{IDW, 8'hf3, 8'he4, 8'h5a, 8'h5b};
      i_eew_master.frame(q, acks);
      `CHK(acks[4:0], 5'h1f)
      wait_ready();
      peek(1'b1, 12'h004, 8'h5a);
      peek(1'b1, 12'h005, 8'h5b);
      q = '{IDW, 8'h04, 8'h00, 8'h02};
      i_eew_master.frame(q, acks);
      `CHK(acks[3:0], 4'hf)
      wait_ready();
      `CHK(id_locked, 1'b1)
      q = '{IDW, 8'h00, 8'h04, 8'h77};
      i_eew_master.frame(q, acks);
      `CHK(acks[3:0], 4'h7)
      wait_ready();
      peek(1'b1, 12'h004, 8'h5a);
      $display("test id page done");
      give_verdict();
   end
endmodule // test_eew_target
